// *** bmx_pkg.sv ***
// package: constants and carriers for the six-layer bus matrix
`default_nettype none
package bmx_pkg;
  localparam int NUM_MASTERS = 6;
  localparam int NUM_SLAVES  = 5;
  localparam int SW          = 3;                 // slave index width
  // master numbering
  localparam logic [2:0] M_CPU_INSTR = 3'h0;
  localparam logic [2:0] M_CPU_DATA  = 3'h1;
  localparam logic [2:0] M_PDMA      = 3'h2;
  localparam logic [2:0] M_IMAGE     = 3'h3;
  localparam logic [2:0] M_ETH       = 3'h4;
  localparam logic [2:0] M_USB       = 3'h5;
  // slave numbering
  localparam logic [2:0] S_SRAM0   = 3'h0;
  localparam logic [2:0] S_SRAM1   = 3'h1;
  localparam logic [2:0] S_ROM_USB = 3'h2;
  localparam logic [2:0] S_EXT     = 3'h3;
  localparam logic [2:0] S_PERIPH  = 3'h4;
  localparam logic [2:0] S_NONE    = 3'h7;        // unused area: abort
  // connectivity: bit m set when master m is wired to the slave
  localparam logic [5:0] CONN_FULL    = 6'h3F;
  localparam logic [5:0] CONN_LIMITED = 6'h07;
  // address map: bank = addr[31:28], inner area = addr[27:20]
  localparam logic [3:0] BANK_INTERNAL = 4'h0;
  localparam logic [3:0] BANK_EXT_LO   = 4'h1;
  localparam logic [3:0] BANK_EXT_HI   = 4'h7;
  localparam logic [3:0] BANK_PERIPH   = 4'hF;
  localparam logic [7:0] AREA_BOOT     = 8'h00;
  localparam logic [7:0] AREA_ROM      = 8'h01;
  localparam logic [7:0] AREA_SRAM0    = 8'h02;
  localparam logic [7:0] AREA_SRAM1    = 8'h03;
  localparam logic [7:0] AREA_USB      = 8'h05;
  // arbitration configuration
  localparam logic [1:0] DEF_NONE  = 2'h0;
  localparam logic [1:0] DEF_LAST  = 2'h1;
  localparam logic [1:0] DEF_FIXED = 2'h2;
  localparam logic [7:0] SLOT_LIMIT_RST = 8'h10;
  localparam logic       REMAP_RST      = 1'b0;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic        last;     // last beat of the master's burst
  } bmx_mreq_s;

  typedef struct packed {
    logic       round_robin;   // 0 fixed priority, 1 round robin
    logic [1:0] def_mode;
    logic [2:0] def_master;
    logic [7:0] slot_limit;    // 0 means no break
  } bmx_arb_cfg_s;
endpackage : bmx_pkg
`default_nettype wire

// *** bmx_matrix.sv ***
// module: six-layer bus matrix decode, connectivity check and per-slave arbitration
`default_nettype none
// What this block does
// (R1) six independent master layers transfer concurrently when targeted slaves are free
// (R2) each master has its own decoder, all using one address map
// (R3) each slave has its own arbiter with independently programmable policy
// (R4) fixed priority or round robin; none, last or fixed default master under round robin only
// (R5) undefined-length bursts accepted, broken at a programmable slot cycle limit
// (R6) boot area routes to internal-boot, external-boot or remap slave
// (R7) boot select pin sampled during reset chooses internal or external boot
// (R8) remap command puts first internal sram at the boot area
// (R9) masters: instruction, data, peripheral dma, image sensor, ethernet, usb dma
// (R10) slaves: sram0, sram1, rom plus usb regs, external port, peripherals
// (R11) every master wired to slaves 0, 1 and 3
// (R12) slaves 2 and 4 reachable only from masters 0, 1 and 2
// (R13) sixteen 256-megabyte banks: 0 internal, 1-7 external, 15 peripherals
// (R14) unused address areas abort the requesting master
// (R15) remap off: pin level 1 maps rom at zero, 0 maps external cs0
// (R16) remap on: pin ignored, first sram at address zero
// (R17) unwired master-slave access errors out and never reaches the slave
// (R18) masters hold request and address until granted and tolerate split bursts
module bmx_matrix
  import bmx_pkg::*;
#(
  parameter int NM = NUM_MASTERS,
  parameter int NS = NUM_SLAVES
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 boot_select_pin,
  input  wire logic                 remap_set,
  input  wire logic                 remap_clear,
  input  wire bmx_arb_cfg_s [NS-1:0] arb_cfg,
  input  wire bmx_mreq_s   [NM-1:0] mreq,
  output logic              [NM-1:0] mgrant,
  output logic              [NM-1:0] merror,
  output logic        [NM-1:0][SW-1:0] mslave,
  output logic        [NS-1:0][SW-1:0] sowner,
  output logic              [NS-1:0] sbusy,
  output logic                      boot_external,
  output logic                      remap_active
);
  // ----------------------------------------------------------------
  // boot select sampling and remap
  // ----------------------------------------------------------------
  logic boot_sync1, boot_sync2;
  logic next_boot_external, next_remap_active;

  // two flops before use; the latched copy tracks only while reset holds
  always_comb begin
    next_boot_external = sys_rst ? ~boot_sync2 : boot_external; // (R7)
    next_remap_active  = remap_active;
    if (remap_set) next_remap_active = 1'b1;                    // (R8)
    else if (remap_clear) next_remap_active = 1'b0;
    if (sys_rst) next_remap_active = REMAP_RST;
  end

  always_ff @(posedge clock) begin
    boot_sync1    <= boot_select_pin;
    boot_sync2    <= boot_sync1;
    boot_external <= next_boot_external;
    remap_active  <= next_remap_active;
  end

  // ----------------------------------------------------------------
  // per-master decoders (one map shared by all)
  // ----------------------------------------------------------------
  function automatic logic [SW-1:0] decode(input logic [31:0] a, input logic remap, input logic ext);
    logic [3:0] bank;
    logic [7:0] area;
    logic [SW-1:0] s;
    bank = a[31:28];
    area = a[27:20];
    s    = S_NONE;                                              // (R14)
    if (bank == BANK_INTERNAL) begin
      unique case (area)
        AREA_BOOT:  s = remap ? S_SRAM0 : (ext ? S_EXT : S_ROM_USB); // (R6) (R15) (R16)
        AREA_ROM:   s = S_ROM_USB;                              // (R10)
        AREA_SRAM0: s = S_SRAM0;
        AREA_SRAM1: s = S_SRAM1;
        AREA_USB:   s = S_ROM_USB;
        default:    s = S_NONE;
      endcase
    end else if (bank >= BANK_EXT_LO && bank <= BANK_EXT_HI) begin
      s = S_EXT;                                                // (R13)
    end else if (bank == BANK_PERIPH) begin
      s = S_PERIPH;
    end
    return s;
  endfunction : decode

  // wiring table: slaves 2 and 4 see only masters 0..2
  function automatic logic [5:0] conn(input logic [SW-1:0] s);
    logic [5:0] c;
    c = 6'h00;
    unique case (s)
      S_SRAM0, S_SRAM1, S_EXT: c = CONN_FULL;                   // (R11)
      S_ROM_USB, S_PERIPH:     c = CONN_LIMITED;                // (R9) (R12)
      default:                 c = 6'h00;
    endcase
    return c;
  endfunction : conn

  logic [NM-1:0][SW-1:0] dec_slave;
  logic [NM-1:0]         dec_ok;
  logic [NS-1:0][NM-1:0] slave_req;

  // decode every layer in parallel; illegal paths never raise a slave request
  always_comb begin
    logic [5:0] wired;
    wired     = 6'h00;
    slave_req = '0;
    for (int m = 0; m < NM; m++) begin
      dec_slave[m] = decode(mreq[m].addr, remap_active, boot_external); // (R2)
      wired        = conn(dec_slave[m]);
      dec_ok[m]    = (dec_slave[m] != S_NONE) && wired[m];              // (R17)
      for (int s = 0; s < NS; s++)
        if (mreq[m].req && dec_ok[m] && dec_slave[m] == SW'(s))
          slave_req[s][m] = 1'b1;                               // (R1)
    end
  end

  // ----------------------------------------------------------------
  // per-slave arbiters
  // ----------------------------------------------------------------
  logic [NS-1:0]         own_valid, next_own_valid;
  logic [NS-1:0][SW-1:0] owner, next_owner;
  logic [NS-1:0][SW-1:0] last_gnt, next_last_gnt;
  logic [NS-1:0][7:0]    slot_cnt, next_slot_cnt;

  // an owner keeps the slave until its burst ends or the slot runs out
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      logic          keep;
      logic          found;
      logic [SW-1:0] pick;
      logic [SW-1:0] idx;
      logic [NM-1:0] cand;
      keep  = 1'b0;
      cand  = slave_req[s];
      found = 1'b0;
      pick  = '0;
      idx   = '0;
      next_own_valid[s] = own_valid[s];
      next_owner[s]     = owner[s];
      next_last_gnt[s]  = last_gnt[s];
      next_slot_cnt[s]  = slot_cnt[s];
      if (own_valid[s]) begin
        keep = slave_req[s][owner[s]] && !mreq[owner[s]].last
               && !(arb_cfg[s].slot_limit != 8'h00 && slot_cnt[s] + 8'h01 >= arb_cfg[s].slot_limit); // (R5)
      end
      // a master on its last beat still shows req; keep it from winning the slave straight back
      if (own_valid[s] && mreq[owner[s]].last) cand[owner[s]] = 1'b0;
      if (keep) begin
        next_slot_cnt[s] = slot_cnt[s] + 8'h01;
      end else begin
        // choose a new owner (R3)
        for (int k = 0; k < NM; k++) begin
          if (arb_cfg[s].round_robin)
            idx = SW'((int'(last_gnt[s]) + 1 + k) % NM);        // (R4)
          else
            idx = SW'(k);                                       // lowest index wins (R4)
          if (!found && cand[idx]) begin
            found = 1'b1;
            pick  = idx;
          end
        end
        next_slot_cnt[s]  = 8'h00;
        next_own_valid[s] = found;
        if (found) begin
          next_owner[s]    = pick;
          next_last_gnt[s] = pick;
        end else if (arb_cfg[s].round_robin) begin
          // idle slave parks on its default master (R4)
          unique case (arb_cfg[s].def_mode)
            DEF_LAST:  next_owner[s] = last_gnt[s];
            DEF_FIXED: next_owner[s] = arb_cfg[s].def_master;
            default:   next_owner[s] = S_NONE;
          endcase
        end else begin
          next_owner[s] = S_NONE;
        end
      end
      if (sys_rst) begin
        next_own_valid[s] = 1'b0;
        next_owner[s]     = S_NONE;
        next_last_gnt[s]  = '0;
        next_slot_cnt[s]  = 8'h00;
      end
    end
  end

  always_ff @(posedge clock) begin
    own_valid <= next_own_valid;
    owner     <= next_owner;
    last_gnt  <= next_last_gnt;
    slot_cnt  <= next_slot_cnt;
  end

  // ----------------------------------------------------------------
  // answers to masters
  // ----------------------------------------------------------------
  // grant is combinational: the master holds its request until then (R18)
  always_comb begin
    for (int m = 0; m < NM; m++) begin
      mgrant[m] = 1'b0;
      merror[m] = mreq[m].req && !dec_ok[m];                    // (R14) (R17)
      mslave[m] = dec_slave[m];
      for (int s = 0; s < NS; s++)
        if (own_valid[s] && owner[s] == SW'(m) && dec_slave[m] == SW'(s) && slave_req[s][m])
          mgrant[m] = 1'b1;
    end
    sowner = owner;
    sbusy  = own_valid;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // remap commands act on the next edge; a set beats a clear
  sequence s_remap_cmd;
    remap_set;
  endsequence : s_remap_cmd
  sequence s_remap_undo;
    remap_clear && !remap_set;
  endsequence : s_remap_undo

  a_remap_on: assert property (@(posedge clock) disable iff (sys_rst) s_remap_cmd |=> remap_active) // (R8)
    else $error("remap stayed off after a set command");
  a_remap_off: assert property (@(posedge clock) disable iff (sys_rst) s_remap_undo |=> !remap_active) // (R8)
    else $error("remap stayed on after a clear command");

  // the sampled boot level must not move once reset is gone
  a_boot_frozen: assert property (@(posedge clock) !sys_rst |=> $stable(boot_external)) // (R7)
    else $error("boot selection changed outside reset");

  // a refused access is never granted, and an idle matrix grants nobody
  a_error_no_grant: assert property (@(posedge clock) disable iff (sys_rst) (merror & mgrant) == '0) // (R17)
    else $error("master granted while its access is refused");
  a_idle_no_grant: assert property (@(posedge clock) disable iff (sys_rst) sbusy == '0 |-> mgrant == '0) // (R4)
    else $error("grant given while every slave is idle");

  // per layer: boot area routing, unused areas and unwired paths
  for (genvar gm = 0; gm < NM; gm++) begin : g_mchk
    a_boot_plain: assert property (@(posedge clock) disable iff (sys_rst) // (R15)
        mreq[gm].req && mreq[gm].addr[31:20] == {BANK_INTERNAL, AREA_BOOT} && !remap_active
        |-> mslave[gm] == (boot_external ? S_EXT : S_ROM_USB))
      else $error("boot area routed to the wrong slave while remap is off");
    a_boot_remap: assert property (@(posedge clock) disable iff (sys_rst) // (R16)
        mreq[gm].req && mreq[gm].addr[31:20] == {BANK_INTERNAL, AREA_BOOT} && remap_active
        |-> mslave[gm] == S_SRAM0)
      else $error("boot area not on the first sram while remap is on");
    a_unused_abort: assert property (@(posedge clock) disable iff (sys_rst) // (R14)
        mreq[gm].req && mslave[gm] == S_NONE |-> merror[gm])
      else $error("access to an unused area was not aborted");
    a_limited_path: assert property (@(posedge clock) disable iff (sys_rst) // (R12)
        mreq[gm].req && !CONN_LIMITED[gm] && (mslave[gm] == S_ROM_USB || mslave[gm] == S_PERIPH)
        |-> merror[gm] && !mgrant[gm])
      else $error("unwired master reached a restricted slave");
  end

  // per slave: an owner never runs past its slot limit
  for (genvar gs = 0; gs < NS; gs++) begin : g_schk
    a_slot_bound: assert property (@(posedge clock) disable iff (sys_rst) // (R5)
        own_valid[gs] && arb_cfg[gs].slot_limit != 8'h00 && $stable(arb_cfg[gs].slot_limit)
        |-> slot_cnt[gs] < arb_cfg[gs].slot_limit)
      else $error("slot counter passed its limit");
  end
endmodule : bmx_matrix
`default_nettype wire

// *** bmx_master_model.sv ***
// partner: one bus master that holds its request until served or aborted
`default_nettype none
module bmx_master_model
  import bmx_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [31:0] addr,
  input  wire logic [7:0]  beats,
  input  wire logic        grant,
  input  wire logic        error,
  output var  bmx_mreq_s   mreq,
  output var  logic        done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  // ----------------------------------------
  // request, hold and release
  // ----------------------------------------
  // a broken burst simply waits with the same address until granted again
  always @(posedge clock) begin
    done <= 1'b0;
    if (sys_rst) begin
      mreq <= '0;
      left <= 8'h00;
    end else if (!mreq.req && start) begin
      mreq <= '{req: 1'b1, addr: addr, last: (beats == 8'h01)};
      left <= beats;
    end else if (mreq.req && (error || (grant && mreq.last))) begin
      mreq.req  <= 1'b0;
      mreq.addr <= ~mreq.addr; // released address never shows the old value
      done      <= 1'b1;
    end else if (mreq.req && grant) begin
      left      <= left - 8'h01;
      mreq.last <= (left == 8'h02);
    end
  end
endmodule : bmx_master_model
`default_nettype wire

// *** bmx_matrix_test.sv ***
// bench: table-driven and hand-written checks of the bus matrix
`default_nettype none
`define CHK(n, g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module bmx_matrix_test
  import bmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] m; logic [31:0] a; logic [2:0] s; logic e;} bmx_row_s;
  logic               clock = 1'b0, sys_rst = 1'b1, pin = 1'b1, remap_set = 1'b0, remap_clear = 1'b0;
  logic [5:0]         start = '0, mgrant, merror, done;
  logic [5:0][31:0]   addr_cmd = '0;
  logic [5:0][7:0]    beats = '0;
  logic [5:0][SW-1:0] mslave;
  logic [4:0][SW-1:0] sowner;
  logic [4:0]         sbusy;
  logic               boot_external, remap_active;
  bmx_arb_cfg_s [4:0] cfg = '0;
  bmx_mreq_s [5:0]    mreq;
  int                 mismatches = 0, total_checks = 0, k;
  bmx_row_s rows [12] = '{'{0, 32'h0010_0000, 2, 0}, '{1, 32'h0020_0000, 0, 0}, '{2, 32'h0030_0000, 1, 0},
    '{3, 32'h2000_0000, 3, 0}, '{4, 32'hF000_0000, 4, 1}, '{5, 32'h0050_0000, 2, 1}, '{0, 32'h8000_0000, 7, 1},
    '{2, 32'h0040_0000, 7, 1}, '{1, 32'h0000_0000, 2, 0}, '{5, 32'h7000_0000, 3, 0},
    '{2, 32'hF000_0000, 4, 0}, '{3, 32'h0020_0000, 0, 0}};
  always #2 clock = ~clock;
  bmx_matrix dut (.clock(clock), .sys_rst(sys_rst), .boot_select_pin(pin), .remap_set(remap_set),
    .remap_clear(remap_clear), .arb_cfg(cfg), .mreq(mreq), .mgrant(mgrant), .merror(merror), .mslave(mslave),
    .sowner(sowner), .sbusy(sbusy), .boot_external(boot_external), .remap_active(remap_active));
  for (genvar m = 0; m < 6; m++) begin : g_mst
    bmx_master_model mst (.clock(clock), .sys_rst(sys_rst), .start(start[m]), .addr(addr_cmd[m]),
      .beats(beats[m]), .grant(mgrant[m]), .error(merror[m]), .mreq(mreq[m]), .done(done[m]));
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report;
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // three edges so the pin crosses its two synchroniser flops
  task automatic reset_with(input logic lvl);
    sys_rst = 1'b1;
    pin = lvl;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
  endtask : reset_with
  task automatic pulse(input logic [5:0] mask);
    start = mask;
    @(negedge clock);
    start = '0;
  endtask : pulse
  task automatic wait_done(input int m);
    k = 0;
    while (done[m] !== 1'b1 && k < 200) begin
      @(negedge clock);
      k++;
    end
    `CHK("done", done[m], 1'b1)
  endtask : wait_done
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_with(1'b1);
    `CHK("boot_external", boot_external, 1'b0)
    `CHK("remap_active", remap_active, 1'b0)
    `CHK("sbusy", sbusy, 5'h00)
    for (int i = 0; i < 12; i++) begin
      addr_cmd[rows[i].m] = rows[i].a;
      beats[rows[i].m] = 8'h01;
      pulse(6'h01 << rows[i].m);
      `CHK("mslave", mslave[rows[i].m], rows[i].s)
      `CHK("merror", merror[rows[i].m], rows[i].e)
      @(negedge clock);
      `CHK("mgrant", mgrant[rows[i].m], ~rows[i].e)
      wait_done(rows[i].m);
    end
    // two masters on one slave plus a third elsewhere, all in the same cycle
    addr_cmd[1] = 32'h0020_0000;
    addr_cmd[4] = 32'h0020_0000;
    addr_cmd[3] = 32'h2000_0000;
    beats = {8'h00, 8'h03, 8'h03, 8'h00, 8'h03, 8'h00};
    pulse(6'h1A);
    @(negedge clock);
    `CHK("owner", sowner[0], M_CPU_DATA)
    `CHK("grant", {mgrant[4], mgrant[3], mgrant[1]}, 3'b011)
    wait_done(1);
    wait_done(3);
    wait_done(4);
    // long burst broken by the slot limit under round robin
    cfg[0] = '{1'b1, DEF_LAST, 3'h0, 8'h04};
    addr_cmd[0] = 32'h0020_0000;
    addr_cmd[5] = 32'h0020_0000;
    beats[0] = 8'h14;
    beats[5] = 8'h02;
    pulse(6'h01);
    pulse(6'h20);
    k = 0;
    while (sowner[0] !== M_USB && k < 8) begin
      @(negedge clock);
      k++;
    end
    `CHK("owner", sowner[0], M_USB)
    `CHK("held", mreq[0].req, 1'b1)
    wait_done(5);
    wait_done(0);
    cfg[0].def_mode = DEF_FIXED;
    cfg[0].def_master = M_ETH;
    repeat (2) @(negedge clock);
    `CHK("parked", sowner[0], M_ETH)
    `CHK("grant", mgrant[4], 1'b0)
    // remap on and off again
    remap_set = 1'b1;
    @(negedge clock);
    remap_set = 1'b0;
    @(negedge clock);
    `CHK("remap_active", remap_active, 1'b1)
    addr_cmd[0] = '0;
    beats[0] = 8'h01;
    pulse(6'h01);
    `CHK("mslave", mslave[0], S_SRAM0)
    wait_done(0);
    remap_clear = 1'b1;
    @(negedge clock);
    remap_clear = 1'b0;
    @(negedge clock);
    `CHK("remap_active", remap_active, 1'b0)
    // second reset with the pin low: boot from the external port
    reset_with(1'b0);
    `CHK("boot_external", boot_external, 1'b1)
    addr_cmd[1] = '0;
    beats[1] = 8'h01;
    pulse(6'h02);
    `CHK("mslave", mslave[1], S_EXT)
    wait_done(1);
    final_report();
  end
endmodule : bmx_matrix_test
`undef CHK
`default_nettype wire
